// ==== core/wss_world_switch.sv ====
`timescale 1ns/100ps
`default_nettype none
module wss_world_switch
    import wss_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic guest_entry_instr_i,
    input wire logic guest_exit_event_i,
    input wire logic encrypted_mode_i,
    input wire logic nested_paging_en_i,
    input wire logic branch_record_supported_i,
    input wire logic branch_record_virt_en_i,
    input wire logic [WSS_ADDR_W-1:0] guest_control_block_i,
    input wire logic [WSS_ADDR_W-1:0] save_state_page_i,
    input wire logic [WSS_ADDR_W-1:0] host_save_page_i,
    input wire logic mem_ack_i,
    input wire logic [WSS_DATA_W-1:0] mem_rdata_i,
    input wire logic [WSS_DATA_W-1:0] reg_rdata_i,
    output wss_mem_req_s mem_req_o,
    output wss_reg_req_s reg_req_o,
    output logic busy_o,
    output logic done_o
);

    // ****************************************
    // Per-item action
    // ****************************************
    typedef enum logic [2:0] {
        WSS_ACT_SKIP,
        WSS_ACT_SAVE_HOST,
        WSS_ACT_SAVE_GUEST,
        WSS_ACT_LOAD_HOST,
        WSS_ACT_LOAD_GUEST,
        WSS_ACT_DEFAULT
    } wss_act_e;

    typedef enum {
        ST_IDLE,
        ST_SCAN,
        ST_MEM,
        ST_REG
    } wss_state_e;

    function automatic wss_act_e item_action(input logic exiting, input logic second_pass,
                                             input wss_class_e cls);
        item_action = WSS_ACT_SKIP;
        if (!exiting && !second_pass)
            item_action = (cls == WSS_CLS_FIRST) ? WSS_ACT_SAVE_HOST : WSS_ACT_SKIP;
        else if (!exiting)
            item_action = WSS_ACT_LOAD_GUEST;
        else if (!second_pass)
            item_action = WSS_ACT_SAVE_GUEST;
        else
        begin
            case (cls)
                WSS_CLS_FIRST: item_action = WSS_ACT_LOAD_HOST;
                WSS_CLS_SECOND: item_action = WSS_ACT_LOAD_HOST;
                WSS_CLS_THIRD: item_action = WSS_ACT_DEFAULT;
                default: item_action = WSS_ACT_SKIP;
            endcase
        end
    endfunction

    wss_item_s item;
    wss_state_e state_reg, state_next;
    logic exiting_reg, exiting_next;
    logic pass_reg, pass_next;
    logic [WSS_IDX_W-1:0] idx_reg, idx_next;
    wss_mem_req_s mem_reg, mem_next;
    wss_reg_req_s regq_reg, regq_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic item_used;
    logic last_item;
    wss_act_e act;
    logic [WSS_ADDR_W-1:0] guest_base;
    logic [WSS_ADDR_W-1:0] host_base;

    wss_item_table u_table
    (
        .idx_i(idx_reg),
        .item_o(item)
    );

    // ****************************************
    // Item gating and addressing
    // ****************************************
    always_comb
    begin
        item_used = 1'b1;
        case (item.use_cond)
            WSS_USE_NESTED_PAGING: item_used = nested_paging_en_i;
            WSS_USE_BRANCH_RECORD: item_used = branch_record_supported_i
                                               && branch_record_virt_en_i;
            default: item_used = 1'b1;
        endcase
        if (!encrypted_mode_i && item.offset >= WSS_PLAIN_RSVD_OFF)
            item_used = 1'b0;
        act = item_used ? item_action(exiting_reg, pass_reg, item.cls) : WSS_ACT_SKIP;
        last_item = (idx_reg == WSS_IDX_W'(WSS_ITEM_COUNT - 1));
        if (encrypted_mode_i)
            guest_base = save_state_page_i + WSS_ADDR_W'(WSS_GUEST_STATE_OFF);
        else
            guest_base = guest_control_block_i + WSS_ADDR_W'(WSS_PLAIN_STATE_OFF);
        host_base = host_save_page_i + WSS_ADDR_W'(WSS_HOST_AREA_OFF);
    end

    // ****************************************
    // Walk sequencer
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        exiting_next = exiting_reg;
        pass_next = pass_reg;
        idx_next = idx_reg;
        mem_next = mem_reg;
        regq_next = regq_reg;
        regq_next.write = 1'b0;
        regq_next.to_default = 1'b0;
        busy_next = busy_reg;
        done_next = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (guest_entry_instr_i || guest_exit_event_i)
                begin
                    exiting_next = guest_exit_event_i;
                    pass_next = 1'b0;
                    idx_next = '0;
                    regq_next.sel = '0;
                    regq_next.sel_valid = 1'b1;
                    busy_next = 1'b1;
                    state_next = ST_SCAN;
                end
            end
            ST_SCAN:
            begin
                // Soft exit fields and the valid mask are not in the walk
                mem_next.wdata = reg_rdata_i;
                mem_next.addr = ((act == WSS_ACT_SAVE_HOST || act == WSS_ACT_LOAD_HOST)
                                 ? host_base : guest_base) + WSS_ADDR_W'(item.offset);
                if (act == WSS_ACT_SAVE_HOST || act == WSS_ACT_SAVE_GUEST)
                begin
                    mem_next.valid = 1'b1;
                    mem_next.write = 1'b1;
                    state_next = ST_MEM;
                end
                else if (act == WSS_ACT_LOAD_HOST || act == WSS_ACT_LOAD_GUEST)
                begin
                    mem_next.valid = 1'b1;
                    mem_next.write = 1'b0;
                    state_next = ST_MEM;
                end
                else if (act == WSS_ACT_DEFAULT)
                begin
                    regq_next.to_default = 1'b1;
                    state_next = ST_REG;
                end
                else
                    state_next = ST_REG;
            end
            ST_MEM:
            begin
                if (mem_ack_i)
                begin
                    mem_next.valid = 1'b0;
                    mem_next.write = 1'b0;
                    if (!mem_reg.write)
                    begin
                        regq_next.write = 1'b1;
                        regq_next.wdata = mem_rdata_i;
                    end
                    state_next = ST_REG;
                end
            end
            default:
            begin
                state_next = ST_SCAN;
                if (last_item && pass_reg)
                begin
                    regq_next.sel_valid = 1'b0;
                    busy_next = 1'b0;
                    done_next = 1'b1;
                    state_next = ST_IDLE;
                end
                else if (last_item)
                begin
                    // Second pass starts only once every first-pass item is done
                    pass_next = 1'b1;
                    idx_next = '0;
                end
                else
                    idx_next = idx_reg + 1'b1;
                regq_next.sel = idx_next;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= ST_IDLE;
            exiting_reg <= 1'b0;
            pass_reg <= 1'b0;
            idx_reg <= '0;
            mem_reg <= '0;
            regq_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            exiting_reg <= exiting_next;
            pass_reg <= pass_next;
            idx_reg <= idx_next;
            mem_reg <= mem_next;
            regq_reg <= regq_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign mem_req_o = mem_reg;
    assign reg_req_o = regq_reg;
    assign busy_o = busy_reg;
    assign done_o = done_reg;

endmodule
`default_nettype wire

// ==== common/wss_pkg.sv ====
`default_nettype none
package wss_pkg;

    // ****************************************
    // Layout of the save-state structure
    // ****************************************
    localparam int WSS_ADDR_W = 52;
    localparam int WSS_DATA_W = 64;
    localparam int WSS_IDX_W = 6;
    localparam int WSS_ITEM_COUNT = 61;
    localparam logic [11:0] WSS_QWORD_BYTES = 12'h008;
    localparam logic [11:0] WSS_GUEST_STATE_OFF = 12'h000;
    localparam logic [11:0] WSS_HOST_AREA_OFF = 12'h400;
    localparam logic [11:0] WSS_PLAIN_STATE_OFF = 12'h400;
    localparam logic [11:0] WSS_PLAIN_RSVD_OFF = 12'h298;
    localparam logic [11:0] WSS_CPL_OFF = 12'h0cb;
    localparam logic [11:0] WSS_EFER_OFF = 12'h0d0;
    localparam logic [11:0] WSS_CR4_OFF = 12'h148;
    localparam logic [11:0] WSS_RSP_OFF = 12'h1d8;
    localparam logic [11:0] WSS_RAX_OFF = 12'h1f8;
    localparam logic [11:0] WSS_STAR_OFF = 12'h200;
    localparam logic [11:0] WSS_CR2_OFF = 12'h240;
    localparam logic [11:0] WSS_PAGE_ATTR_OFF = 12'h268;
    localparam logic [11:0] WSS_DEBUG_CTL_OFF = 12'h270;
    localparam logic [11:0] WSS_RCX_OFF = 12'h308;
    localparam logic [11:0] WSS_RBP_OFF = 12'h328;
    localparam logic [11:0] WSS_XCR0_OFF = 12'h3e8;
    // Segment classes, one bit per segment, set means second class
    localparam logic [9:0] WSS_SEG_SECOND_MASK = 10'h2b0;

    // ****************************************
    // Item index bounds in the walk
    // ****************************************
    localparam logic [5:0] WSS_IX_CPL = 6'h14;
    localparam logic [5:0] WSS_IX_EFER = 6'h15;
    localparam logic [5:0] WSS_IX_CR4 = 6'h16;
    localparam logic [5:0] WSS_IX_RSP = 6'h1d;
    localparam logic [5:0] WSS_IX_RAX = 6'h1e;
    localparam logic [5:0] WSS_IX_STAR = 6'h1f;
    localparam logic [5:0] WSS_IX_CR2 = 6'h27;
    localparam logic [5:0] WSS_IX_PAGE_ATTR = 6'h28;
    localparam logic [5:0] WSS_IX_DEBUG_CTL = 6'h29;
    localparam logic [5:0] WSS_IX_RCX = 6'h2e;
    localparam logic [5:0] WSS_IX_RBP = 6'h31;
    localparam logic [5:0] WSS_IX_XCR0 = 6'h3c;

    typedef enum logic [1:0] {
        WSS_CLS_FIRST,
        WSS_CLS_SECOND,
        WSS_CLS_THIRD,
        WSS_CLS_GUEST_ONLY
    } wss_class_e;

    typedef enum logic [1:0] {
        WSS_USE_ALWAYS,
        WSS_USE_NESTED_PAGING,
        WSS_USE_BRANCH_RECORD
    } wss_use_e;

    typedef struct packed {
        logic [11:0] offset;
        wss_class_e cls;
        wss_use_e use_cond;
    } wss_item_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [WSS_ADDR_W-1:0] addr;
        logic [WSS_DATA_W-1:0] wdata;
    } wss_mem_req_s;

    typedef struct packed {
        logic sel_valid;
        logic [WSS_IDX_W-1:0] sel;
        logic write;
        logic to_default;
        logic [WSS_DATA_W-1:0] wdata;
    } wss_reg_req_s;

endpackage
`default_nettype wire

// ==== core/wss_item_table.sv ====
`timescale 1ns/100ps
`default_nettype none
module wss_item_table
    import wss_pkg::*;
(
    input wire logic [WSS_IDX_W-1:0] idx_i,
    output wss_item_s item_o
);

    // ****************************************
    // Offset of a linear run of qwords
    // ****************************************
    function automatic logic [11:0] run_off(input logic [11:0] base, input logic [5:0] first,
                                            input logic [5:0] ix);
        logic [11:0] step;
        step = {6'h00, ix - first};
        run_off = base + step * WSS_QWORD_BYTES;
    endfunction

    always_comb
    begin
        item_o.use_cond = WSS_USE_ALWAYS;
        item_o.cls = WSS_CLS_FIRST;
        item_o.offset = WSS_GUEST_STATE_OFF;
        if (idx_i < WSS_IX_CPL)
        begin
            item_o.offset = run_off(WSS_GUEST_STATE_OFF, 6'h00, idx_i);
            item_o.cls = WSS_SEG_SECOND_MASK[idx_i[4:1]] ? WSS_CLS_SECOND : WSS_CLS_FIRST;
        end
        else if (idx_i == WSS_IX_CPL)
            item_o.offset = WSS_CPL_OFF;
        else if (idx_i == WSS_IX_EFER)
            item_o.offset = WSS_EFER_OFF;
        else if (idx_i < WSS_IX_RSP)
            item_o.offset = run_off(WSS_CR4_OFF, WSS_IX_CR4, idx_i);
        else if (idx_i == WSS_IX_RSP)
            item_o.offset = WSS_RSP_OFF;
        else if (idx_i == WSS_IX_RAX)
            item_o.offset = WSS_RAX_OFF;
        else if (idx_i < WSS_IX_CR2)
        begin
            item_o.offset = run_off(WSS_STAR_OFF, WSS_IX_STAR, idx_i);
            item_o.cls = WSS_CLS_SECOND;
        end
        else if (idx_i == WSS_IX_CR2)
        begin
            item_o.offset = WSS_CR2_OFF;
            item_o.cls = WSS_CLS_THIRD;
        end
        else if (idx_i == WSS_IX_PAGE_ATTR)
        begin
            item_o.offset = WSS_PAGE_ATTR_OFF;
            item_o.cls = WSS_CLS_GUEST_ONLY;
            item_o.use_cond = WSS_USE_NESTED_PAGING;
        end
        else if (idx_i < WSS_IX_RCX)
        begin
            item_o.offset = run_off(WSS_DEBUG_CTL_OFF, WSS_IX_DEBUG_CTL, idx_i);
            item_o.use_cond = WSS_USE_BRANCH_RECORD;
        end
        else if (idx_i < WSS_IX_RBP)
        begin
            item_o.offset = run_off(WSS_RCX_OFF, WSS_IX_RCX, idx_i);
            item_o.cls = WSS_CLS_SECOND;
        end
        else if (idx_i < WSS_IX_XCR0)
        begin
            item_o.offset = run_off(WSS_RBP_OFF, WSS_IX_RBP, idx_i);
            item_o.cls = WSS_CLS_SECOND;
        end
        else
        begin
            item_o.offset = WSS_XCR0_OFF;
            item_o.cls = WSS_CLS_SECOND;
        end
    end

endmodule
`default_nettype wire

// ==== test/wss_world_switch_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module wss_world_switch_asserts
    import wss_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic guest_entry_instr_i,
    input wire logic guest_exit_event_i,
    input wire logic mem_ack_i,
    input wire logic [WSS_DATA_W-1:0] mem_rdata_i,
    input wire logic [WSS_DATA_W-1:0] reg_rdata_i,
    input wire wss_mem_req_s mem_req_o,
    input wire wss_reg_req_s reg_req_o,
    input wire logic busy_o,
    input wire logic done_o
);
    // Set once a register load has been issued in this switch
    logic ld_reg;
    logic ld_next;
    always_comb
    begin
        ld_next = busy_o && (ld_reg || reg_req_o.write);
    end
    always_ff @(posedge sys_clk_i)
    begin
        ld_reg <= rst_b_i && ld_next;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_start;
        !busy_o && (guest_entry_instr_i || guest_exit_event_i);
    endsequence
    sequence s_rd_ack;
        mem_req_o.valid && !mem_req_o.write && mem_ack_i;
    endsequence
    a_busy_on_start: assert property (s_start |=> busy_o)
        else $error("no busy after start");
    a_load_follows: assert property (s_rd_ack |=> reg_req_o.write
        && reg_req_o.wdata == $past(mem_rdata_i))
        else $error("load missing after read");
    a_load_cause: assert property (reg_req_o.write |-> $past(mem_ack_i)
        && $past(mem_req_o.valid) && !$past(mem_req_o.write))
        else $error("load without read");
    a_save_data: assert property (mem_req_o.valid && mem_req_o.write
        |-> mem_req_o.wdata == reg_rdata_i)
        else $error("saved data wrong");
    a_req_held: assert property (mem_req_o.valid && !mem_ack_i |=> mem_req_o.valid
        && $stable(mem_req_o.addr) && $stable(mem_req_o.write))
        else $error("request dropped");
    a_idle_quiet: assert property (!busy_o |-> !mem_req_o.valid)
        else $error("request while idle");
    a_save_first: assert property (ld_reg |-> !(mem_req_o.valid && mem_req_o.write))
        else $error("save after load");
    a_pulse_single: assert property (reg_req_o.write || reg_req_o.to_default
        |=> !reg_req_o.write && !reg_req_o.to_default)
        else $error("register pulse too long");
    a_done_single: assert property (done_o |=> !done_o && !busy_o)
        else $error("done too long");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i
        |=> !busy_o && !done_o && !mem_req_o.valid && !reg_req_o.sel_valid)
        else $error("outputs live in reset");
endmodule
bind wss_world_switch wss_world_switch_asserts wss_world_switch_asserts_inst (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .guest_entry_instr_i(guest_entry_instr_i),
    .guest_exit_event_i(guest_exit_event_i),
    .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i),
    .reg_rdata_i(reg_rdata_i),
    .mem_req_o(mem_req_o),
    .reg_req_o(reg_req_o),
    .busy_o(busy_o),
    .done_o(done_o)
);
`default_nettype wire

// ==== test/wss_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module wss_far_model
    import wss_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire wss_mem_req_s mem_req_i,
    input wire wss_reg_req_s reg_req_i,
    output logic mem_ack_o,
    output logic [WSS_DATA_W-1:0] mem_rdata_o,
    output logic [WSS_DATA_W-1:0] reg_rdata_o
);
    logic [1:0] wait_reg;
    // Reply after 0 to 3 extra cycles, by address
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || mem_ack_o)
        begin
            mem_ack_o <= 1'b0;
            wait_reg <= 2'h0;
        end
        else if (mem_req_i.valid)
        begin
            mem_ack_o <= wait_reg == mem_req_i.addr[4:3];
            wait_reg <= wait_reg + 2'h1;
        end
    end
    // Inverted word outside ack; valid mask words get no special meaning
    assign mem_rdata_o = {12'h3c3, mem_req_i.addr} ^ {64{!mem_ack_o}};
    assign reg_rdata_o = {16'ha5a5, 42'h0, reg_req_i.sel};
endmodule
`default_nettype wire

// ==== test/wss_world_switch_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module wss_world_switch_tb_top
    import wss_pkg::*;
();
    typedef struct packed {
        logic flag;
        logic [WSS_ADDR_W-1:0] addr;
        logic [WSS_DATA_W-1:0] data;
    } wss_tb_op_s;
    localparam logic [51:0] GCB = 52'h0000_1111_2000;
    localparam logic [51:0] SSP = 52'h0000_3333_4000;
    localparam logic [51:0] HSP = 52'h0000_5555_6000;
    logic sys_clk;
    logic rst_b;
    logic entry;
    logic exit_ev;
    logic [3:0] mode;
    logic ack;
    logic [63:0] rdata;
    logic [63:0] regval;
    wss_mem_req_s mreq;
    wss_reg_req_s rreq;
    logic busy;
    logic done;
    wss_tb_op_s memq[$];
    wss_tb_op_s regq[$];
    int mismatches = 0;
    int checks = 0;
    int dflts = 0;
    // Exit, encrypted, nested, branch supported, branch enabled, default pulses
    logic [5:0] rows [6] = '{6'h1e, 6'h3f, 6'h04, 6'h2b, 6'h31, 6'h16};
    wss_world_switch wss_world_switch_inst (
        .sys_clk_i(sys_clk),
        .rst_b_i(rst_b),
        .guest_entry_instr_i(entry),
        .guest_exit_event_i(exit_ev),
        .encrypted_mode_i(mode[3]),
        .nested_paging_en_i(mode[2]),
        .branch_record_supported_i(mode[1]),
        .branch_record_virt_en_i(mode[0]),
        .guest_control_block_i(GCB),
        .save_state_page_i(SSP),
        .host_save_page_i(HSP),
        .mem_ack_i(ack),
        .mem_rdata_i(rdata),
        .reg_rdata_i(regval),
        .mem_req_o(mreq),
        .reg_req_o(rreq),
        .busy_o(busy),
        .done_o(done)
    );
    wss_far_model wss_far_model_inst (
        .clk_i(sys_clk),
        .rst_b_i(rst_b),
        .mem_req_i(mreq),
        .reg_req_i(rreq),
        .mem_ack_o(ack),
        .mem_rdata_o(rdata),
        .reg_rdata_o(regval)
    );
    // ****
    // Expected walk
    // ****
    function automatic logic [11:0] off_of(int i);
        case (i) inside
            [0:19]: return 12'(i * 8);
            20: return 12'h0cb;
            21: return 12'h0d0;
            [22:28]: return 12'(12'h148 + (i - 22) * 8);
            29: return 12'h1d8;
            30: return 12'h1f8;
            [31:39]: return 12'(12'h200 + (i - 31) * 8);
            [40:45]: return 12'(12'h268 + (i - 40) * 8);
            [46:48]: return 12'(12'h308 + (i - 46) * 8);
            [49:59]: return 12'(12'h328 + (i - 49) * 8);
            default: return 12'h3e8;
        endcase
    endfunction
    // 0 first, 1 second, 2 third, 3 guest only
    function automatic int cls_of(int i);
        case (i) inside
            [8:11], 14, 15, 18, 19: return 1;
            [0:30], [41:45]: return 0;
            39: return 2;
            40: return 3;
            default: return 1;
        endcase
    endfunction
    function automatic bit used(int i);
        if (!mode[3] && off_of(i) >= 12'h298) return 0;
        if (i == 40) return mode[2];
        if (i > 40 && i < 46) return mode[1] && mode[0];
        return 1;
    endfunction
    task automatic build(bit ex);
        logic [51:0] g;
        logic [51:0] h;
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 61; i++)
            begin
                g = (mode[3] ? SSP : GCB + 52'h400) + 52'(off_of(i));
                h = HSP + 52'h400 + 52'(off_of(i));
                if (!used(i)) continue;
                if (p == 0 && (ex || cls_of(i) == 0))
                    memq.push_back({1'b1, ex ? g : h, 16'ha5a5, 42'h0, 6'(i)});
                else if (p == 1 && ex && cls_of(i) == 2)
                    regq.push_back({1'b1, 52'(i), 64'h0});
                else if (p == 1 && (!ex || cls_of(i) < 2))
                begin
                    memq.push_back({1'b0, ex ? h : g, 64'h0});
                    regq.push_back({1'b0, 52'(i), 12'h3c3, ex ? h : g});
                end
            end
    endtask
    // ****
    // Compare and report
    // ****
    task automatic chk_op(ref wss_tb_op_s q[$], input wss_tb_op_s got);
        checks++;
        if (q.size() == 0 || q[0] !== got)
        begin
            mismatches++;
            $display("BAD %0t unexpected transfer %h", $time, got);
        end
        if (q.size() != 0) void'(q.pop_front());
    endtask
    task automatic chk_bit(logic got, logic exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t flag %b not %b", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(int got, int exp);
        checks++;
        if (got != exp)
        begin
            mismatches++;
            $display("BAD %0t count %0d not %0d", $time, got, exp);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(negedge sys_clk)
    begin
        if (rst_b && mreq.valid && ack)
            chk_op(memq, {mreq.write, mreq.addr, mreq.write ? mreq.wdata : 64'h0});
        if (rst_b && (rreq.write || rreq.to_default))
        begin
            chk_op(regq, {rreq.to_default, 52'(rreq.sel), rreq.write ? rreq.wdata : 64'h0});
            dflts += int'(rreq.to_default);
        end
    end
    task automatic run(logic [5:0] r, bit both, bit late);
        int n;
        mode = r[4:1];
        dflts = 0;
        build(r[5]);
        entry = !r[5] || both;
        exit_ev = r[5];
        n = 0;
        while (done !== 1'b1 && n < 3000)
        begin
            @(negedge sys_clk);
            entry = late && n == 20;
            exit_ev = 1'b0;
            n++;
            if (n == 1)
                chk_bit(busy & rreq.sel_valid, 1'b1);
        end
        chk_bit(done, 1'b1);
        chk_bit(busy | rreq.sel_valid, 1'b0);
        @(negedge sys_clk);
        chk_bit(done, 1'b0);
        chk_cnt(memq.size() + regq.size(), 0);
        chk_cnt(dflts, int'(r[0]));
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        final_report();
    end
    initial
    begin
        rst_b = 1'b0;
        entry = 1'b0;
        exit_ev = 1'b0;
        mode = 4'h0;
        repeat (16) @(negedge sys_clk);
        chk_bit(busy | done | mreq.valid, 1'b0);
        rst_b = 1'b1;
        foreach (rows[k]) run(rows[k], 1'b0, 1'b0);
        run(6'h1e, 1'b0, 1'b1);
        run(6'h3f, 1'b1, 1'b0);
        // Reset in mid-walk
        mode = 4'hf;
        build(1'b0);
        entry = 1'b1;
        @(negedge sys_clk);
        entry = 1'b0;
        repeat (30) @(negedge sys_clk);
        rst_b = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk_bit(busy | done | mreq.valid | rreq.sel_valid, 1'b0);
        memq.delete();
        regq.delete();
        rst_b = 1'b1;
        run(6'h31, 1'b0, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
